// ==== wan_sync_frame_port_test.sv ====
`timescale 1ns/1ps
module wan_sync_frame_port_test;
  import wsf_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  wsf_beat_t tx_beat = '0;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic stall = 1'b0;
  logic drain = 1'b0;
  logic tx_ready, rx_valid, link_rx_sample_clock, link_rx_word_qualifier;
  logic link_rx_accept_ready, link_tx_launch_clock, link_tx_word_qualifier;
  logic link_tx_send_permit;
  logic [7:0] rx_word, link_rx_word, link_tx_word;
  int seed = 69;
  int err_total = 0;
  int total_checks = 0;
  logic [7:0] exp_tx[$];
  logic [7:0] exp_rx[$];
  logic [7:0] got_rx[$];
  logic sel_ser = 1'b0;
  logic s_tx_ready, s_clk, s_q;
  logic [0:0] s_bit;
  logic [SCR_LEN-1:0] dscr = SCR_INIT;
  logic ser_bits[$];
  logic exp_bits[$];
  always #5 mclk = ~mclk;
  wsf_port dut_u (.*, .tx_valid(tx_valid && !sel_ser));
  wsf_link_model lm_u (.*);
  // The serial build shares the beat source; its receive side stays idle.
  wsf_port #(.DW(1)) ser_u (
    .mclk(mclk),
    .rst(rst),
    .tx_beat(tx_beat),
    .tx_valid(tx_valid && sel_ser),
    .tx_ready(s_tx_ready),
    .rx_word(),
    .rx_valid(),
    .rx_ready(1'b0),
    .link_rx_sample_clock(1'b0),
    .link_rx_word_qualifier(1'b0),
    .link_rx_word(1'b0),
    .link_rx_accept_ready(),
    .link_tx_launch_clock(s_clk),
    .link_tx_word_qualifier(s_q),
    .link_tx_word(s_bit),
    .link_tx_send_permit(1'b1)
  );
  // Far-end descrambler; it shifts in the line bit, so it needs no frame alignment.
  always @(posedge s_clk) begin
    if (s_q === 1'b1) begin
      ser_bits.push_back(s_bit[0] ^ dscr[SCR_TAP_A] ^ dscr[SCR_TAP_B]);
      dscr = {dscr[SCR_LEN-2:0], s_bit[0]};
    end
  end
  always @(negedge mclk) rx_ready <= drain & 1'($random(seed));
  always @(posedge mclk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      got_rx.push_back(rx_word);
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : crc_byte
  task automatic put_frame(input int n);
    logic [15:0] c;
    logic [7:0] d;
    int k;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      d = (i == 1) ? 8'hff : 8'($random(seed));
      c = crc_byte(c, d);
      exp_tx.push_back(d);
      tx_beat = '{data: d, last: (i == n - 1)};
      tx_valid = 1'b1;
      k = 0;
      while ((sel_ser ? s_tx_ready : tx_ready) !== 1'b1 && k < 400) begin
        @(negedge mclk);
        k++;
      end
      @(posedge mclk);
    end
    @(negedge mclk);
    tx_valid = 1'b0;
    exp_tx.push_back(c[15:8]);
    exp_tx.push_back(c[7:0]);
  endtask : put_frame
  initial begin
    #400000;
    err_total++;
    summarize();
  end
  initial begin
    int n, k, ones;
    logic [7:0] d;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    put_frame(1);
    for (int f = 0; f < 4; f++) begin
      put_frame(2 + ($random(seed) & 7));
    end
    // A stall in mid-frame must freeze the link without losing a byte.
    fork
      put_frame(12);
      begin
        repeat (8) @(negedge mclk);
        stall = 1'b1;
        repeat (8) @(negedge mclk);
        chk(16'(link_tx_word_qualifier), 16'h0000);
        repeat (20) @(negedge mclk);
        stall = 1'b0;
      end
    join
    k = 0;
    while (lm_u.txq.size() < exp_tx.size() && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    repeat (20) @(negedge mclk);
    chk(16'(lm_u.txq.size()), 16'(exp_tx.size()));
    foreach (exp_tx[i]) chk(16'(lm_u.txq[i]), 16'(exp_tx[i]));
    n = 0;
    while (link_rx_accept_ready === 1'b1 && n < 20) begin
      @(negedge mclk);
      d = 8'($random(seed));
      if (n == 3) lm_u.put_word(~d, 1'b0);
      lm_u.put_word(d, 1'b1);
      exp_rx.push_back(d);
      n++;
    end
    chk(16'(n >= 12 && n <= 13), 16'h0001);
    drain = 1'b1;
    k = 0;
    while (got_rx.size() < n && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    chk(16'(got_rx.size()), 16'(n));
    foreach (exp_rx[i]) chk(16'(got_rx[i]), 16'(exp_rx[i]));
    chk(16'(link_rx_accept_ready), 16'h0001);
    // Serial build: the descrambled stream is flag, stuffed data and CRC, flag.
    exp_tx.delete();
    sel_ser = 1'b1;
    put_frame(6);
    for (int i = 0; i < BYTE_BITS; i++) begin
      exp_bits.push_back(HDLC_FLAG[i]);
    end
    ones = 0;
    foreach (exp_tx[j]) begin
      for (int i = 0; i < BYTE_BITS; i++) begin
        exp_bits.push_back(exp_tx[j][i]);
        ones = exp_tx[j][i] ? ones + 1 : 0;
        if (ones == STUFF_RUN) begin
          exp_bits.push_back(1'b0);
          ones = 0;
        end
      end
    end
    for (int i = 0; i < BYTE_BITS; i++) begin
      exp_bits.push_back(HDLC_FLAG[i]);
    end
    k = 0;
    while (ser_bits.size() < exp_bits.size() && k < 4000) begin
      @(negedge mclk);
      k++;
    end
    repeat (20) @(negedge mclk);
    chk(16'(ser_bits.size()), 16'(exp_bits.size()));
    foreach (exp_bits[i]) chk(16'(ser_bits[i]), 16'(exp_bits[i]));
    summarize();
  end
endmodule : wan_sync_frame_port_test

// ==== wsf_crc.sv ====
`timescale 1ns/1ps
module wsf_crc
  import wsf_pkg::*;
#(
  parameter int unsigned DW = 8
) (
  input wire logic [CRC_W-1:0] crc_in,
  input wire logic [DW-1:0] data,
  output logic [CRC_W-1:0] crc_out
);
  // Bits are folded in least significant first, matching the wire order.
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc_out = crc_in;
    for (int i = 0; i < DW; i++) begin
      fb = crc_out[CRC_W-1] ^ data[i];
      crc_out = {crc_out[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    end
  end
endmodule : wsf_crc

// ==== wsf_link_model.sv ====
`timescale 1ns/1ps
module wsf_link_model (
  input wire logic link_tx_launch_clock,
  input wire logic link_tx_word_qualifier,
  input wire logic [7:0] link_tx_word,
  output logic link_tx_send_permit,
  output logic link_rx_sample_clock,
  output logic link_rx_word_qualifier,
  output logic [7:0] link_rx_word,
  input wire logic stall
);
  logic [7:0] txq[$];
  // The far end drives the permit pin high and pulls it low only while stall is set.
  assign link_tx_send_permit = !stall;
  always @(posedge link_tx_launch_clock) begin
    if (link_tx_word_qualifier === 1'b1) begin
      txq.push_back(link_tx_word);
    end
  end
  initial begin
    link_rx_sample_clock = 1'b0;
    link_rx_word_qualifier = 1'b0;
    link_rx_word = 8'h00;
  end
  // One word per 140 ns, far below the 100 MHz mclk so the mclk edge detector sees every edge.
  task automatic put_word(input logic [7:0] d, input logic q);
    link_rx_word = d;
    link_rx_word_qualifier = q;
    #40 link_rx_sample_clock = 1'b1;
    #60 link_rx_sample_clock = 1'b0;
    link_rx_word_qualifier = 1'b0;
    link_rx_word = 8'h00;
    #40;
  endtask : put_word
endmodule : wsf_link_model

// ==== wsf_pkg.sv ====
package wsf_pkg;
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [7:0] HDLC_FLAG = 8'h7e;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam int unsigned CRC_W = 16;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam int unsigned SCR_LEN = 7;
  localparam int unsigned SCR_TAP_A = 3;
  localparam int unsigned SCR_TAP_B = 6;
  localparam logic [6:0] SCR_INIT = 7'h7f;
  localparam real MCLK_MHZ = 100.0;
  localparam real TX_CLK_MHZ = 125.0;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } wsf_beat_t;

  typedef enum {
    WSF_IDLE,
    WSF_OPEN,
    WSF_DATA,
    WSF_CRC_HI,
    WSF_CRC_LO,
    WSF_CLOSE
  } wsf_unit_t;
endpackage : wsf_pkg

// ==== wsf_port.sv ====
`timescale 1ns/1ps
module wsf_port
  import wsf_pkg::*;
#(
  parameter int unsigned DW = 8,
  parameter int unsigned RX_DEPTH = 16,
  parameter int unsigned RX_MARGIN = 4,
  parameter int unsigned TX_DIV = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire wsf_beat_t tx_beat,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [DW-1:0] rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic link_rx_sample_clock,
  input wire logic link_rx_word_qualifier,
  input wire logic [DW-1:0] link_rx_word,
  output logic link_rx_accept_ready,
  output logic link_tx_launch_clock,
  output logic link_tx_word_qualifier,
  output logic [DW-1:0] link_tx_word,
  input wire logic link_tx_send_permit
);
  localparam bit SER = (DW == 1);
  localparam int unsigned AW = $clog2(RX_DEPTH);
  localparam logic [3:0] DW_STEP = 4'(DW);
  localparam logic [3:0] UNIT_BITS = 4'(BYTE_BITS);
  localparam logic [7:0] DIV_LAST = 8'(TX_DIV - 1);
  localparam logic [AW:0] RX_LIMIT = (AW+1)'(RX_DEPTH - RX_MARGIN);

  initial begin
    if (DW != 1 && DW != 8) $error("DW must be 1 or 8");
    if (RX_DEPTH < 2 || (1 << AW) != RX_DEPTH) $error("RX_DEPTH must be a power of two");
    if (RX_MARGIN >= RX_DEPTH) $error("RX_MARGIN must be below RX_DEPTH");
    if (TX_DIV < 1 || TX_DIV > 256) $error("TX_DIV out of range");
  end

  // Pin synchronisers; the first stage feeds only the second.
  logic rxc_s1_ff, rxc_s2_ff, rxc_s3_ff, rxq_s1_ff, rxq_s2_ff, prm_s1_ff, prm_s2_ff;
  logic [DW-1:0] rxd_s1_ff, rxd_s2_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxc_s1_ff <= 1'b0;
      rxc_s2_ff <= 1'b0;
      rxc_s3_ff <= 1'b0;
      rxq_s1_ff <= 1'b0;
      rxq_s2_ff <= 1'b0;
      rxd_s1_ff <= '0;
      rxd_s2_ff <= '0;
      prm_s1_ff <= 1'b0;
      prm_s2_ff <= 1'b0;
    end else begin
      rxc_s1_ff <= link_rx_sample_clock;
      rxc_s2_ff <= rxc_s1_ff;
      rxc_s3_ff <= rxc_s2_ff;
      rxq_s1_ff <= link_rx_word_qualifier;
      rxq_s2_ff <= rxq_s1_ff;
      rxd_s1_ff <= link_rx_word;
      rxd_s2_ff <= rxd_s1_ff;
      prm_s1_ff <= link_tx_send_permit;
      prm_s2_ff <= prm_s1_ff;
    end
  end

  // Receive elastic buffer. The margin absorbs words already in flight through
  // the synchronisers when clear-to-send drops.
  logic [DW-1:0] rx_mem [RX_DEPTH];
  logic [AW-1:0] rx_wp_ff, rx_rp_ff;
  logic [AW:0] rx_cnt_ff;
  logic rx_push, rx_pop;
  assign rx_push = rxc_s2_ff && !rxc_s3_ff && rxq_s2_ff && (rx_cnt_ff != (AW+1)'(RX_DEPTH));
  assign rx_pop = (rx_cnt_ff != '0) && (!rx_valid || rx_ready);

  always_ff @(posedge mclk) begin
    if (rx_push) begin
      rx_mem[rx_wp_ff] <= rxd_s2_ff;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_wp_ff <= '0;
      rx_rp_ff <= '0;
      rx_cnt_ff <= '0;
      link_rx_accept_ready <= 1'b0;
    end else begin
      if (rx_push) rx_wp_ff <= rx_wp_ff + 1'b1;
      if (rx_pop) rx_rp_ff <= rx_rp_ff + 1'b1;
      rx_cnt_ff <= rx_cnt_ff + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      link_rx_accept_ready <= (rx_cnt_ff + (AW+1)'(rx_push)) < RX_LIMIT;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_word <= '0;
    end else if (rx_pop) begin
      rx_valid <= 1'b1;
      rx_word <= rx_mem[rx_rp_ff];
    end else if (rx_ready) begin
      rx_valid <= 1'b0;
    end
  end

  // Transmit clock divider. Data is launched as the clock falls so that the
  // far end sees it stable at the following rising edge.
  logic [7:0] div_ff;
  logic launch_en;
  assign launch_en = (div_ff == DIV_LAST) && link_tx_launch_clock;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_ff <= '0;
      link_tx_launch_clock <= 1'b0;
    end else if (div_ff == DIV_LAST) begin
      div_ff <= '0;
      link_tx_launch_clock <= !link_tx_launch_clock;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // Input holding register towards the framer.
  wsf_beat_t hold_ff;
  logic hold_full_ff, take_hold;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_ff <= '0;
      hold_full_ff <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) begin
        hold_ff <= tx_beat;
        hold_full_ff <= 1'b1;
        tx_ready <= 1'b0;
      end else if (take_hold) begin
        hold_full_ff <= 1'b0;
        tx_ready <= 1'b1;
      end else begin
        tx_ready <= !hold_full_ff;
      end
    end
  end

  // Framer: one unit (flag, data byte or CRC byte) shifted out DW bits per launch.
  wsf_unit_t st_ff, nxt_st;
  logic [7:0] sh_ff, nxt_sh;
  logic [3:0] bit_ff;
  logic [2:0] ones_ff;
  logic unit_vld_ff, nxt_vld, last_ff, nxt_last;
  logic [CRC_W-1:0] crc_ff, crc_upd;
  logic [SCR_LEN-1:0] scr_ff;
  logic act, need_stuff, unit_done, do_load, emit;
  logic [DW-1:0] emit_bits, out_word;
  logic scr_bit;

  assign act = launch_en && prm_s2_ff;
  assign need_stuff = SER && unit_vld_ff && (ones_ff == STUFF_RUN);
  assign emit = act && unit_vld_ff;
  assign unit_done = emit && !need_stuff && (bit_ff + DW_STEP == UNIT_BITS);
  assign do_load = act && (!unit_vld_ff || unit_done);
  assign emit_bits = need_stuff ? '0 : sh_ff[DW-1:0];
  assign scr_bit = emit_bits[0] ^ scr_ff[SCR_TAP_A] ^ scr_ff[SCR_TAP_B];

  wsf_crc #(.DW(DW)) u_crc (
    .crc_in(crc_ff),
    .data(emit_bits),
    .crc_out(crc_upd)
  );

  always_comb begin
    out_word = emit_bits;
    if (SER) out_word[0] = scr_bit;
  end

  // A mid-frame underrun stalls with the qualifier low; in serial mode the
  // far end sees this as a gap, so the source should keep the holding register fed.
  always_comb begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_vld = 1'b0;
    nxt_last = last_ff;
    take_hold = 1'b0;
    case (st_ff)
      WSF_IDLE: begin
        if (hold_full_ff && SER) begin
          nxt_st = WSF_OPEN;
          nxt_sh = HDLC_FLAG;
          nxt_vld = 1'b1;
        end else if (hold_full_ff) begin
          nxt_st = WSF_DATA;
          {nxt_sh, nxt_last} = hold_ff;
          nxt_vld = 1'b1;
          take_hold = do_load;
        end
      end
      WSF_OPEN, WSF_DATA: begin
        if (st_ff == WSF_DATA && last_ff) begin
          nxt_st = WSF_CRC_HI;
          nxt_sh = crc_upd[15:8];
          nxt_vld = 1'b1;
        end else if (hold_full_ff) begin
          nxt_st = WSF_DATA;
          {nxt_sh, nxt_last} = hold_ff;
          nxt_vld = 1'b1;
          take_hold = do_load;
        end
      end
      WSF_CRC_HI: begin
        nxt_st = WSF_CRC_LO;
        nxt_sh = crc_ff[7:0];
        nxt_vld = 1'b1;
      end
      WSF_CRC_LO: begin
        nxt_st = SER ? WSF_CLOSE : WSF_IDLE;
        nxt_sh = HDLC_FLAG;
        nxt_vld = SER;
      end
      WSF_CLOSE: begin
        nxt_st = WSF_IDLE;
      end
      default: begin
        nxt_st = WSF_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= WSF_IDLE;
      sh_ff <= '0;
      bit_ff <= '0;
      unit_vld_ff <= 1'b0;
      last_ff <= 1'b0;
    end else if (do_load) begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      bit_ff <= '0;
      unit_vld_ff <= nxt_vld;
      last_ff <= nxt_last;
    end else if (emit && !need_stuff) begin
      sh_ff <= 8'(sh_ff >> DW);
      bit_ff <= bit_ff + DW_STEP;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crc_ff <= CRC_INIT;
      ones_ff <= '0;
      scr_ff <= SCR_INIT;
    end else begin
      if (act && st_ff == WSF_IDLE) begin
        crc_ff <= CRC_INIT;
      end else if (emit && !need_stuff && st_ff == WSF_DATA) begin
        crc_ff <= crc_upd;
      end
      if (emit && SER) begin
        scr_ff <= {scr_ff[SCR_LEN-2:0], scr_bit};
        if (need_stuff || st_ff == WSF_OPEN || st_ff == WSF_CLOSE || !emit_bits[0]) begin
          ones_ff <= '0;
        end else begin
          ones_ff <= ones_ff + 3'h1;
        end
      end
    end
  end

  // One word per launch at full rate gives the documented throughput ceiling.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_tx_word_qualifier <= 1'b0;
      link_tx_word <= '0;
    end else if (launch_en) begin
      link_tx_word_qualifier <= emit;
      if (emit) link_tx_word <= out_word;
    end
  end
endmodule : wsf_port

// ==== wsf_port_checker.sv ====
`timescale 1ns/1ps
module wsf_port_checker
  import wsf_pkg::*;
#(
  parameter int unsigned DW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [DW-1:0] rx_word,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic link_rx_sample_clock,
  input wire logic link_rx_word_qualifier,
  input wire logic link_rx_accept_ready,
  input wire logic link_tx_launch_clock,
  input wire logic link_tx_word_qualifier,
  input wire logic [DW-1:0] link_tx_word,
  input wire logic link_tx_send_permit
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // The launch clock is a divided mclk, so its edges are visible as mclk samples.
  a_qual_on_fall: assert property ($changed(link_tx_word_qualifier) |-> $fell(link_tx_launch_clock))
    else $error("tx qualifier moved off a launch fall");
  a_word_on_fall: assert property ($changed(link_tx_word) |-> $fell(link_tx_launch_clock))
    else $error("tx word moved off a launch fall");
  a_clk_toggle: assert property (link_tx_launch_clock |=> !link_tx_launch_clock ##1 link_tx_launch_clock)
    else $error("launch clock not toggling");
  a_permit_block: assert property (!link_tx_send_permit [*5] |-> !link_tx_word_qualifier)
    else $error("tx qualifier high while blocked");
  a_qual_permit: assert property ($rose(link_tx_word_qualifier) |-> $past(link_tx_send_permit, 2))
    else $error("tx qualifier rose without permit");
  a_ready_drop: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("tx ready stayed high after a take");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
    else $error("rx word not held");
  a_rx_capture: assert property ($rose(link_rx_sample_clock)
      && link_rx_word_qualifier && link_rx_accept_ready |-> ##[1:8] rx_valid)
    else $error("captured word never surfaced");
  a_accept_stop: assert property ((rx_valid && !rx_ready) [*3]
      ##0 !link_rx_accept_ready |=> !link_rx_accept_ready)
    else $error("accept ready rose with no drain");
  c_tx_word: cover property (link_tx_word_qualifier && $fell(link_tx_launch_clock));
  c_rx_full: cover property (!link_rx_accept_ready);
  c_tx_stall: cover property (tx_valid && !link_tx_send_permit);
endmodule : wsf_port_checker
bind wsf_port wsf_port_checker #(.DW(DW)) chk_u (.*);
